// ==== include/ssq_pkg.sv ====
package ssq_pkg;
  // Register window and offsets (32-bit address, byte addresses)
  localparam logic [31:0] SYS_BASE = 32'hFFFF_F000;
  localparam logic [31:0] SYS_LAST = 32'hFFFF_FFFF;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_DROP = 12'h004;
  localparam logic [11:0] OFF_RSTC = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_IRQS = 12'h010;
  localparam logic [11:0] OFF_IRQM = 12'h014;
  // Control register fields
  localparam int CTRL_XTAL_EN = 0;
  localparam int CTRL_XTAL_SEL = 1;
  localparam int CTRL_MAIN_EXT = 2;
  localparam int CTRL_IDLE = 3;
  localparam int CTRL_SW_RST = 4;
  // Drop detector fields
  localparam int DROP_EN = 0;
  localparam int DROP_SWITCHED = 1;
  localparam int DROP_RST_MODE = 2;
  localparam int DROP_THR_LSB = 4;
  localparam int DROP_THR_W = 4;
  // Threshold: 1.9 V to 3.4 V in 100 mV steps
  localparam int THR_MIN_MV = 1900;
  localparam int THR_MAX_MV = 3400;
  localparam int THR_STEP_MV = 100;
  localparam logic [3:0] THR_MAX_CODE = 4'((THR_MAX_MV - THR_MIN_MV) / THR_STEP_MV);
  // Interrupt status bits
  localparam int IRQ_DROP = 0;
  localparam int IRQ_RST = 1;
  localparam int IRQ_W = 2;
  // Reset value and timing constants
  localparam logic [7:0] EXT_RST_LEN_RST = 8'h0_4;
  localparam logic [7:0] SAMPLE_PERIOD = 8'h1_F;
  localparam logic [3:0] SAMPLE_ON_CYC = 4'h3;
  localparam logic [3:0] PWR_STEP_CYC = 4'h4;
  // Slow and main clock figures
  localparam int SLOW_CLK_HZ = 32768;
  localparam int MAIN_RC_HZ = 2000000;

  typedef enum logic [2:0] {
    SSQ_OFF = 3'b000, SSQ_SWITCH = 3'b001, SSQ_REG = 3'b010, SSQ_CORE_RST = 3'b011, SSQ_RUN = 3'b100
  } ssq_seq_e;

  typedef enum logic [2:0] {
    SSQ_C_POWERUP = 3'b000, SSQ_C_SOFT = 3'b001, SSQ_C_USER = 3'b010, SSQ_C_WDOG = 3'b011,
    SSQ_C_DROP = 3'b100
  } ssq_cause_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssq_bus_s;

  typedef struct packed {
    logic power_switch;
    logic regulator;
    logic core_reset;
  } ssq_pwr_s;

  // Register hit inside the system window
  function automatic logic ssq_hit(input logic [31:0] a, input logic [11:0] off);
    return (a[31:12] == SYS_BASE[31:12]) && (a[11:0] == off);
  endfunction
endpackage

// ==== src/ssq_drop_sampler.sv ====
`timescale 1ns/100ps
// Switched sampling of the drop detector with latched, synchronised result
module ssq_drop_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic switched,
  // Analog detector
  input wire logic detector_out,
  output logic detector_on,
  // Result
  output logic drop_level
);
  logic [7:0] period_q;
  logic meta_q;
  logic sync_q;
  logic hold_q;

  // Period counter; in switched mode the detector is powered only in the first cycles of it
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      period_q <= 8'h0_0;
    end else if (period_q == ssq_pkg::SAMPLE_PERIOD) begin
      period_q <= 8'h0_0;
    end else begin
      period_q <= period_q + 8'h0_1;
    end
  end

  always_comb begin
    detector_on = enable && (!switched || period_q < 8'(ssq_pkg::SAMPLE_ON_CYC) + 8'h0_2);
  end

  // Two-stage synchroniser on the detector output
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= detector_out && detector_on;
      sync_q <= meta_q;
    end
  end

  // Latch: in switched mode only the settled sample at the end of the on window counts
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      hold_q <= 1'b0;
    end else if (!switched || period_q == 8'(ssq_pkg::SAMPLE_ON_CYC) + 8'h0_1) begin
      hold_q <= sync_q;
    end
  end

  assign drop_level = hold_q;
endmodule

// ==== src/ssq_top.sv ====
`timescale 1ns/100ps
// Functional notes
// - Registers decode only in the top 4 KB window FFFF_F000 to FFFF_FFFF.
// - The sequencer has its own power-on reset and runs only on the slow clock.
// - Slow clock starts on the RC oscillator; software may enable then select the crystal.
// - The RC oscillator is switched off while the crystal is selected; the crystal runs whenever enabled.
// - Power switches, then regulator, then core resets are released in sequence.
// - Power-on reset always acts and resets the whole sequencer.
// - The drop detector is off after reset until software enables it.
// - The threshold code selects 1.9 V to 3.4 V in 100 mV steps.
// - Software chooses whether a drop wakes the system or resets it.
// - Switched mode powers the detector periodically and latches its output.
// - The cause of the last reset is recorded and readable.
// - Internal and external resets are driven; the pin pulse length is programmable.
// - Main clock starts on the fast RC; software may switch to the external input.
// - Processor clock is gated off in idle until an interrupt arrives.
module ssq_top (
  // Slow clock and power-on reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire ssq_pkg::ssq_bus_s BUS,
  output logic [31:0] RDATA,
  // Reset and wake sources
  input wire logic USER_RST,
  input wire logic WDOG_RST,
  input wire logic WAKE_IRQ,
  // Drop detector
  input wire logic DETECTOR_OUT,
  output logic DETECTOR_ON,
  output logic [3:0] DETECTOR_THR,
  // Supply control
  output ssq_pkg::ssq_pwr_s PWR,
  // Clock selection
  output logic RC_OSC_EN,
  output logic XTAL_OSC_EN,
  output logic SLOW_SEL_XTAL,
  output logic MAIN_SEL_EXT,
  output logic PROC_CLK_EN,
  // Reset and wake outputs
  output logic EXT_RST_N_OUT,
  output logic EXT_RST_N_OE_N,
  output logic DROP_WAKE,
  output logic IRQ
);
  ssq_pkg::ssq_seq_e seq_q;
  ssq_pkg::ssq_cause_e cause_q;
  logic [3:0] step_q;
  logic [4:0] ctrl_q;
  logic [7:0] drop_q;
  logic [7:0] rst_len_q;
  logic [7:0] pulse_q;
  logic [ssq_pkg::IRQ_W-1:0] irqs_q;
  logic [ssq_pkg::IRQ_W-1:0] irqm_q;
  logic [31:0] rdata_q;
  logic xtal_sel_q;
  logic idle_q;
  logic drop_level;
  logic drop_prev_q;
  logic drop_rise;
  logic drop_reset;
  logic sw_reset;
  logic any_reset;
  logic [ssq_pkg::IRQ_W-1:0] irq_set;
  logic [ssq_pkg::IRQ_W-1:0] irq_clr;
  logic det_on;
  logic wr_ctrl;
  logic wr_drop;

  assign wr_ctrl = BUS.wr && ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_CTRL);
  assign wr_drop = BUS.wr && ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_DROP);

  // Control register; soft reset bit is a self-clearing strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= 5'h0_0;
    end else if (wr_ctrl) begin
      ctrl_q <= BUS.wdata[4:0];
    end else begin
      ctrl_q[ssq_pkg::CTRL_SW_RST] <= 1'b0;
    end
  end
  assign sw_reset = ctrl_q[ssq_pkg::CTRL_SW_RST];

  // Drop detector configuration; threshold codes above the top level clamp
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      drop_q <= 8'h0_0;
    end else if (wr_drop) begin
      drop_q[2:0] <= BUS.wdata[2:0];
      drop_q[3] <= 1'b0;
      drop_q[7:4] <= (BUS.wdata[7:4] > ssq_pkg::THR_MAX_CODE) ? ssq_pkg::THR_MAX_CODE : BUS.wdata[7:4];
    end
  end

  // Reset pulse length register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_len_q <= ssq_pkg::EXT_RST_LEN_RST;
    end else if (BUS.wr && ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_RSTC)) begin
      rst_len_q <= (BUS.wdata[7:0] == 8'h0_0) ? 8'h0_1 : BUS.wdata[7:0];
    end
  end

  ssq_drop_sampler u_drop (
    .clk(CLK),
    .rst(SYS_RST),
    .enable(drop_q[ssq_pkg::DROP_EN]),
    .switched(drop_q[ssq_pkg::DROP_SWITCHED]),
    .detector_out(DETECTOR_OUT),
    .detector_on(det_on),
    .drop_level(drop_level)
  );

  // Edge of the held drop level, routed by the mode bit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      drop_prev_q <= 1'b0;
    end else begin
      drop_prev_q <= drop_level;
    end
  end
  assign drop_rise = drop_level && !drop_prev_q;
  assign drop_reset = drop_rise && drop_q[ssq_pkg::DROP_RST_MODE];
  assign any_reset = sw_reset || USER_RST || WDOG_RST || drop_reset;

  // Power-up sequence: switches, regulator, core reset hold, run
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      seq_q <= ssq_pkg::SSQ_OFF;
      step_q <= 4'h0;
    end else if (any_reset && seq_q == ssq_pkg::SSQ_RUN) begin
      seq_q <= ssq_pkg::SSQ_CORE_RST;
      step_q <= 4'h0;
    end else if (step_q != ssq_pkg::PWR_STEP_CYC) begin
      step_q <= step_q + 4'h1;
    end else begin
      step_q <= 4'h0;
      unique case (seq_q)
        ssq_pkg::SSQ_OFF: seq_q <= ssq_pkg::SSQ_SWITCH;
        ssq_pkg::SSQ_SWITCH: seq_q <= ssq_pkg::SSQ_REG;
        ssq_pkg::SSQ_REG: seq_q <= ssq_pkg::SSQ_CORE_RST;
        ssq_pkg::SSQ_CORE_RST: seq_q <= (pulse_q == 8'h0_0) ? ssq_pkg::SSQ_RUN : ssq_pkg::SSQ_CORE_RST;
        ssq_pkg::SSQ_RUN: seq_q <= ssq_pkg::SSQ_RUN;
        default: seq_q <= ssq_pkg::SSQ_OFF;
      endcase
    end
  end

  // Supply outputs follow the sequencer state; core reset is asserted only once the core domain is powered
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PWR <= '0;
    end else begin
      PWR.power_switch <= seq_q != ssq_pkg::SSQ_OFF;
      PWR.regulator <= seq_q >= ssq_pkg::SSQ_REG;
      PWR.core_reset <= seq_q == ssq_pkg::SSQ_CORE_RST;
    end
  end

  // Cause of last reset; power-up until another cause occurs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cause_q <= ssq_pkg::SSQ_C_POWERUP;
    end else if (seq_q == ssq_pkg::SSQ_RUN) begin
      if (drop_reset) begin
        cause_q <= ssq_pkg::SSQ_C_DROP;
      end else if (WDOG_RST) begin
        cause_q <= ssq_pkg::SSQ_C_WDOG;
      end else if (USER_RST) begin
        cause_q <= ssq_pkg::SSQ_C_USER;
      end else if (sw_reset) begin
        cause_q <= ssq_pkg::SSQ_C_SOFT;
      end
    end
  end

  // External pin pulse stretcher, reloaded by every reset request taken in the run state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pulse_q <= ssq_pkg::EXT_RST_LEN_RST;
    end else if (any_reset && seq_q == ssq_pkg::SSQ_RUN) begin
      pulse_q <= rst_len_q;
    end else if (seq_q == ssq_pkg::SSQ_CORE_RST && pulse_q != 8'h0_0) begin
      pulse_q <= pulse_q - 8'h0_1;
    end
  end

  // Pin is open drain: driven low from reset through power-up and while the pulse runs, released otherwise
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      EXT_RST_N_OUT <= 1'b0;
      EXT_RST_N_OE_N <= 1'b0;
    end else begin
      EXT_RST_N_OUT <= 1'b0;
      EXT_RST_N_OE_N <= (seq_q == ssq_pkg::SSQ_RUN) || (pulse_q == 8'h0_0 && seq_q == ssq_pkg::SSQ_CORE_RST);
    end
  end

  // Slow clock select; switching waits for the crystal to be enabled
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      xtal_sel_q <= 1'b0;
    end else begin
      xtal_sel_q <= ctrl_q[ssq_pkg::CTRL_XTAL_SEL] && ctrl_q[ssq_pkg::CTRL_XTAL_EN];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RC_OSC_EN <= 1'b1;
      XTAL_OSC_EN <= 1'b0;
      SLOW_SEL_XTAL <= 1'b0;
      MAIN_SEL_EXT <= 1'b0;
    end else begin
      RC_OSC_EN <= !xtal_sel_q;
      XTAL_OSC_EN <= ctrl_q[ssq_pkg::CTRL_XTAL_EN] || xtal_sel_q;
      SLOW_SEL_XTAL <= xtal_sel_q;
      MAIN_SEL_EXT <= ctrl_q[ssq_pkg::CTRL_MAIN_EXT];
    end
  end

  // Idle: processor clock gated until an interrupt wakes it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      idle_q <= 1'b0;
    end else if (WAKE_IRQ || IRQ) begin
      idle_q <= 1'b0;
    end else if (wr_ctrl && BUS.wdata[ssq_pkg::CTRL_IDLE]) begin
      idle_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PROC_CLK_EN <= 1'b0;
      DETECTOR_ON <= 1'b0;
      DETECTOR_THR <= 4'h0;
      DROP_WAKE <= 1'b0;
    end else begin
      PROC_CLK_EN <= (seq_q == ssq_pkg::SSQ_RUN) && !idle_q && !(wr_ctrl && BUS.wdata[ssq_pkg::CTRL_IDLE]);
      DETECTOR_ON <= det_on;
      DETECTOR_THR <= drop_q[7:4];
      DROP_WAKE <= drop_level && !drop_q[ssq_pkg::DROP_RST_MODE];
    end
  end

  // Sticky interrupt status; set wins over write-one clear
  assign irq_set = {drop_reset || any_reset, drop_rise && !drop_q[ssq_pkg::DROP_RST_MODE]};
  assign irq_clr = (BUS.wr && ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_IRQS)) ? BUS.wdata[ssq_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irqs_q <= '0;
      irqm_q <= '0;
      IRQ <= 1'b0;
    end else begin
      irqs_q <= (irqs_q & ~irq_clr) | irq_set;
      if (BUS.wr && ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_IRQM)) begin
        irqm_q <= BUS.wdata[ssq_pkg::IRQ_W-1:0];
      end
      IRQ <= |(((irqs_q & ~irq_clr) | irq_set) & irqm_q);
    end
  end

  // Read port: data in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (BUS.rd) begin
      rdata_q <= 32'h0000_0000;
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_CTRL)) rdata_q <= {27'h0, ctrl_q};
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_DROP)) rdata_q <= {24'h0, drop_q};
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_RSTC)) rdata_q <= {24'h0, rst_len_q};
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_STAT)) begin
        rdata_q <= {22'h0, drop_level, idle_q, seq_q, xtal_sel_q, 1'b0, cause_q};
      end
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_IRQS)) rdata_q <= {30'h0, irqs_q};
      if (ssq_pkg::ssq_hit(BUS.addr, ssq_pkg::OFF_IRQM)) rdata_q <= {30'h0, irqm_q};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign RDATA = rdata_q;
endmodule

// ==== testbench/ssq_top_assertions.sv ====
`timescale 1ns/100ps
// Port checks of the sequencer
module ssq_top_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Inputs
  input wire ssq_pkg::ssq_bus_s BUS,
  input wire logic USER_RST,
  input wire logic WDOG_RST,
  input wire logic WAKE_IRQ,
  // Outputs
  input wire logic [31:0] RDATA,
  input wire ssq_pkg::ssq_pwr_s PWR,
  input wire logic RC_OSC_EN,
  input wire logic XTAL_OSC_EN,
  input wire logic SLOW_SEL_XTAL,
  input wire logic MAIN_SEL_EXT,
  input wire logic PROC_CLK_EN,
  input wire logic DETECTOR_ON,
  input wire logic EXT_RST_N_OUT,
  input wire logic EXT_RST_N_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Set once start-up released the core, since requests before that are ignored
  logic run_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) run_q <= 1'b0;
    else if ($fell(PWR.core_reset)) run_q <= 1'b1;
  end
  a_reset_defaults: assert property (
    $fell(SYS_RST) |-> RC_OSC_EN && !SLOW_SEL_XTAL && !MAIN_SEL_EXT && !DETECTOR_ON && !EXT_RST_N_OE_N)
    else $error("reset defaults wrong");
  a_osc_select: assert property (
    (RC_OSC_EN != SLOW_SEL_XTAL) && (XTAL_OSC_EN || !SLOW_SEL_XTAL))
    else $error("unused oscillator on");
  a_reg_order: assert property (
    $rose(PWR.regulator) |-> $past(PWR.power_switch, 4))
    else $error("regulator too early");
  a_core_after_reg: assert property (
    PWR.core_reset |-> PWR.regulator && PWR.power_switch)
    else $error("core reset without supply");
  a_rdata_idle: assert property (
    !BUS.rd |=> RDATA == 32'h0000_0000)
    else $error("read data outside slot");
  a_unmapped_read: assert property (
    BUS.rd && BUS.addr[31:12] != 20'hF_FFFF |=> RDATA == 32'h0000_0000)
    else $error("read outside window answered");
  a_pin_in_reset: assert property (
    $rose(PWR.core_reset) |-> !EXT_RST_N_OE_N && !EXT_RST_N_OUT)
    else $error("pin not driven at core reset");
  a_pin_released: assert property (
    run_q && !PWR.core_reset |-> EXT_RST_N_OE_N)
    else $error("pin driven while core runs");
  a_pin_drive_low: assert property (
    !EXT_RST_N_OUT)
    else $error("pin driven high");
  a_reset_request: assert property (
    run_q && !PWR.core_reset && (USER_RST || WDOG_RST) |-> ##[1:3] PWR.core_reset)
    else $error("reset request lost");
  a_idle_wake: assert property (
    run_q && !PWR.core_reset && !PROC_CLK_EN && WAKE_IRQ |-> ##[1:3] PROC_CLK_EN)
    else $error("wake did not restart clock");
  c_start: cover property ($fell(PWR.core_reset));
  c_xtal: cover property (SLOW_SEL_XTAL);
  c_sample: cover property ($rose(DETECTOR_ON));
endmodule

// ==== testbench/ssq_supply_model.sv ====
`timescale 1ns/100ps
// Supply drop comparator powered by the sequencer
module ssq_supply_model (
  // Clock and answer speed
  input wire logic clk,
  input wire logic slow,
  // Control from the sequencer
  input wire logic detector_on,
  input wire logic [3:0] detector_thr,
  // Supply level in millivolts
  input wire logic [15:0] supply_mv,
  // Result
  output logic detector_out
);
  logic cmp_q = 1'b0;
  logic out_q = 1'b0;
  wire logic below = int'(supply_mv) < ssq_pkg::THR_MIN_MV + ssq_pkg::THR_STEP_MV * int'(detector_thr);
  assign detector_out = out_q;
  // Unpowered output floats, so it toggles rather than holding; slow settles a cycle later
  always @(posedge clk) begin
    cmp_q <= below;
    if (!detector_on) out_q <= !out_q;
    else out_q <= slow ? cmp_q : below;
  end
endmodule

// ==== testbench/tb_supply_reset_clock_sequencer.sv ====
`timescale 1ns/100ps
// Register-level tests of the sequencer
module tb_supply_reset_clock_sequencer;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ssq_pkg::ssq_bus_s bus = '0;
  logic user_rst = 1'b0, wdog_rst = 1'b0, wake_irq = 1'b0, slow = 1'b0;
  logic det_out, det_on, rc_en, xt_en, sel_xt, main_ext, pclk_en, pin_out, pin_oe_n, drop_wake, irq;
  logic [3:0] thr;
  logic [15:0] supply_mv = 16'h0E10; // 3600 mV
  logic [31:0] rdata, rd_q;
  ssq_pkg::ssq_pwr_s pwr;
  int errors = 0, checks_done = 0, n = 0, cyc = 0, ps_t = 0, rg_t = 0;
  // Clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  ssq_top dut (.CLK(clk), .SYS_RST(sys_rst), .BUS(bus), .RDATA(rdata), .USER_RST(user_rst),
    .WDOG_RST(wdog_rst), .WAKE_IRQ(wake_irq), .DETECTOR_OUT(det_out), .DETECTOR_ON(det_on),
    .DETECTOR_THR(thr), .PWR(pwr), .RC_OSC_EN(rc_en), .XTAL_OSC_EN(xt_en), .SLOW_SEL_XTAL(sel_xt),
    .MAIN_SEL_EXT(main_ext), .PROC_CLK_EN(pclk_en), .EXT_RST_N_OUT(pin_out), .EXT_RST_N_OE_N(pin_oe_n),
    .DROP_WAKE(drop_wake), .IRQ(irq));
  ssq_supply_model u_supply (.clk(clk), .slow(slow), .detector_on(det_on), .detector_thr(thr),
    .supply_mv(supply_mv), .detector_out(det_out));
  // First rise of each supply stage, in cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pwr.power_switch === 1'b1 && ps_t == 0) ps_t <= cyc;
    if (pwr.regulator === 1'b1 && rg_t == 0) rg_t <= cyc;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write, then let derived outputs settle; some outputs sit two registers behind the field
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    @(posedge clk) bus <= '{{20'hF_FFFF, off}, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] off, input logic [19:0] page = 20'hF_FFFF);
    @(posedge clk) bus <= '{{page, off}, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 rd_q = rdata;
  endtask
  // Bounded wait on core reset (0) or held drop level (1)
  task automatic wait_sig(input int which, input logic lvl);
    n = 0;
    while ((which == 1 ? drop_wake : pwr.core_reset) !== lvl && n < 100) begin
      @(posedge clk) #1 n++;
    end
    chk("wait", 32'(n < 100), 32'h0000_0001);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk("reset outs", {pwr, rc_en, xt_en, sel_xt, main_ext, pin_oe_n, det_on}, 32'h0000_0020);
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    chk("stage gap", 32'(rg_t - ps_t), 32'(ssq_pkg::PWR_STEP_CYC) + 32'h0000_0001);
    chk("proc clock", pclk_en, 32'h0000_0001);
    rd(ssq_pkg::OFF_STAT);
    chk("status", rd_q & 32'h0000_03FF, 32'h0000_0080);
    rd(ssq_pkg::OFF_RSTC);
    chk("pulse len", rd_q, 32'h0000_0004);
    rd(ssq_pkg::OFF_STAT, 20'hF_FFFE);
    chk("outside", rd_q, 32'h0000_0000);
    rd(12'h018);
    chk("unmapped", rd_q, 32'h0000_0000);
    wr(ssq_pkg::OFF_CTRL, 32'h0000_0001);
    chk("xtal on", {rc_en, sel_xt}, 32'h0000_0002);
    wr(ssq_pkg::OFF_CTRL, 32'h0000_0007);
    chk("xtal sel", {rc_en, xt_en, sel_xt, main_ext}, 32'h0000_0007);
    wr(ssq_pkg::OFF_CTRL, 32'h0000_000B);
    repeat (4) @(posedge clk);
    #1 chk("idle", pclk_en, 32'h0000_0000);
    @(posedge clk) wake_irq <= 1'b1;
    @(posedge clk) wake_irq <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("woken", pclk_en, 32'h0000_0001);
    for (int c = 0; c < 16; c++) begin
      wr(ssq_pkg::OFF_DROP, 32'(c) << 4);
      chk("thr", {det_on, thr}, 32'(c));
    end
    supply_mv = 16'h0BB8; // 3000 mV
    wr(ssq_pkg::OFF_DROP, 32'h0000_00F1);
    wait_sig(1, 1'b1);
    chk("masked", irq, 32'h0000_0000);
    rd(ssq_pkg::OFF_IRQS);
    chk("event", rd_q[0], 32'h0000_0001);
    wr(ssq_pkg::OFF_IRQM, 32'h0000_0001);
    chk("unmasked", irq, 32'h0000_0001);
    supply_mv = 16'h0E10;
    wait_sig(1, 1'b0);
    wr(ssq_pkg::OFF_IRQS, 32'h0000_0001);
    chk("cleared", irq, 32'h0000_0000);
    // Switched mode: five on-cycles in every 32, slow comparator
    supply_mv = 16'h0BB8;
    slow = 1'b1;
    wr(ssq_pkg::OFF_DROP, 32'h0000_00F3);
    n = 0;
    repeat (64) begin
      @(posedge clk) #1 n += int'(det_on === 1'b1);
    end
    chk("on cycles", 32'(n), 32'h0000_000A);
    chk("latched", drop_wake, 32'h0000_0001);
    supply_mv = 16'h0E10;
    repeat (3) @(posedge clk);
    #1 chk("held", drop_wake, 32'h0000_0001);
    repeat (64) @(posedge clk);
    #1 chk("resampled", drop_wake, 32'h0000_0000);
    slow = 1'b0;
    wr(ssq_pkg::OFF_IRQS, 32'h0000_0001);
    supply_mv = 16'h0BB8;
    wr(ssq_pkg::OFF_DROP, 32'h0000_00F5);
    wait_sig(0, 1'b1);
    supply_mv = 16'h0E10;
    wait_sig(0, 1'b0);
    rd(ssq_pkg::OFF_STAT);
    chk("drop cause", rd_q[2:0], 32'h0000_0004);
    wr(ssq_pkg::OFF_DROP, 32'h0000_0000);
    wr(ssq_pkg::OFF_RSTC, 32'h0000_0008);
    // Soft, user, watchdog, then user with watchdog
    for (int k = 0; k < 4; k++) begin
      if (k == 0) begin
        wr(ssq_pkg::OFF_CTRL, 32'h0000_0013);
      end else begin
        @(posedge clk) {wdog_rst, user_rst} <= 2'(k);
        @(posedge clk) {wdog_rst, user_rst} <= 2'b00;
      end
      wait_sig(0, 1'b1);
      n = 0;
      while (pin_oe_n === 1'b0 && n < 100) begin
        @(posedge clk) #1 n++;
      end
      chk("pin pulse", 32'(n), 32'h0000_0008);
      wait_sig(0, 1'b0);
      rd(ssq_pkg::OFF_STAT);
      chk("cause", rd_q[2:0], (k == 3) ? 32'h0000_0003 : 32'(k + 1));
    end
    @(posedge clk) sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    rd(ssq_pkg::OFF_STAT);
    chk("por again", rd_q & 32'h0000_03FF, 32'h0000_0080);
    report_and_stop();
  end
  // Cut a hang short
  initial begin
    #3_000_000;
    errors++;
    report_and_stop();
  end
endmodule
bind ssq_top ssq_top_assertions u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .BUS(BUS), .USER_RST(USER_RST),
  .WDOG_RST(WDOG_RST), .WAKE_IRQ(WAKE_IRQ), .RDATA(RDATA), .PWR(PWR), .RC_OSC_EN(RC_OSC_EN),
  .XTAL_OSC_EN(XTAL_OSC_EN), .SLOW_SEL_XTAL(SLOW_SEL_XTAL), .MAIN_SEL_EXT(MAIN_SEL_EXT),
  .PROC_CLK_EN(PROC_CLK_EN), .DETECTOR_ON(DETECTOR_ON), .EXT_RST_N_OUT(EXT_RST_N_OUT),
  .EXT_RST_N_OE_N(EXT_RST_N_OE_N));
